/* logic/core_branch_pkg.sv */
// Operation
// - exchange timing: register 1/1, direct 2/2, indirect 1/2
// - carry bit logic ops: two bytes, two cycles
// - carry jumps: two bytes, 2/3 cycles
// - bit jumps 3 bytes 3/4; clear-variant clears bit
// - short jump: two bytes, three cycles
// - pointer-indirect jump: one byte, three cycles
// - accumulator zero jumps: two bytes, 2/3 cycles
// - compare jumps: three bytes, 3/4 cycles
// - indirect compare jump: three bytes, 4/5 cycles
// - direct decrement jump: three bytes, 3/4 cycles
// - no-op and unused opcode: 1 byte, 1 cycle
// - register field picks bank register zero-seven
// - indirect address comes from register 0 or 1
// - relative target = next address plus signed offset
// - direct below 0x80 RAM, else special registers
// - page target replaces low eleven address bits
// - long target carries full sixteen bits
// - pointer low byte at 0x82, resets zero
// - pointer high byte at 0x83, resets zero
// - stack pointer increments before each push
// - stack pointer resets to seven
// - bank n spans RAM 8n to 8n+7
// - untaken branch finishes one cycle sooner
package core_branch_pkg;
    localparam logic [7:0] ADDR_STACK  = 8'h81;  // Stack top pointer
    localparam logic [7:0] ADDR_PTR_LO = 8'h82;  // Pointer low byte
    localparam logic [7:0] ADDR_PTR_HI = 8'h83;  // Pointer high byte
    localparam logic [7:0] STACK_RESET = 8'h07;  // Just below bank 1
    localparam logic [7:0] PTR_RESET   = 8'h00;
    // Opcodes
    localparam logic [7:0] OP_NOP    = 8'h00;
    localparam logic [7:0] OP_UNUSED = 8'ha5;
    localparam logic [7:0] OP_XCH_D  = 8'hc5;
    localparam logic [7:0] OP_ANL_B  = 8'h82;
    localparam logic [7:0] OP_ANL_NB = 8'hb0;
    localparam logic [7:0] OP_ORL_B  = 8'h72;
    localparam logic [7:0] OP_ORL_NB = 8'ha0;
    localparam logic [7:0] OP_MOV_CB = 8'ha2;
    localparam logic [7:0] OP_MOV_BC = 8'h92;
    localparam logic [7:0] OP_JC     = 8'h40;
    localparam logic [7:0] OP_JNC    = 8'h50;
    localparam logic [7:0] OP_JB     = 8'h20;
    localparam logic [7:0] OP_JNB    = 8'h30;
    localparam logic [7:0] OP_JBC    = 8'h10;
    localparam logic [7:0] OP_LONG_JUMP   = 8'h02;
    localparam logic [7:0] OP_LONG_CALL  = 8'h12;
    localparam logic [7:0] OP_SHORT_RELATIVE_JUMP   = 8'h80;
    localparam logic [7:0] OP_JMPI   = 8'h73;
    localparam logic [7:0] OP_JZ     = 8'h60;
    localparam logic [7:0] OP_JNZ    = 8'h70;
    localparam logic [7:0] OP_CJ_AD  = 8'hb5;
    localparam logic [7:0] OP_CJ_AI  = 8'hb4;
    localparam logic [7:0] OP_DJ_D   = 8'hd5;
    localparam logic [7:0] SFR_FIRST = 8'h80;  // Start of special space
    typedef enum logic [2:0] {T_NEXT, T_REL, T_PAGE, T_LONG, T_PTR} target_e;
endpackage : core_branch_pkg

/* logic/core_branch_bit_timing.sv */
`timescale 1ns/100ps
module core_branch_bit_timing
    import core_branch_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        instrValid,   // Opcode and operands present
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  operand1,     // Second instruction byte
    input  wire logic [7:0]  operand2,     // Third instruction byte
    input  wire logic [15:0] pc,           // Address of the opcode byte
    input  wire logic [1:0]  bankSelect,   // Bank select bits
    input  wire logic        carryFlag,
    input  wire logic [7:0]  accValue,
    input  wire logic        testBit,      // Value of the addressed bit
    input  wire logic        compareUnequal,
    input  wire logic [7:0]  decValue,     // Direct byte before decrement
    input  wire logic        sfrWrite,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic [7:0]  sfrWdata,
    input  wire logic        pushReq,
    input  wire logic        popReq,
    output logic             ready,        // Next opcode may be taken
    output logic             done,         // Last cycle of instruction
    output logic [1:0]       instrLength,  // Bytes consumed
    output logic [2:0]       cycleCount,   // Cycles this instruction takes
    output logic             branchTaken,
    output logic [15:0]      targetAddr,   // Next program address
    output logic [7:0]       bankRegAddr,  // RAM address of register field
    output logic [7:0]       indirectRegAddr,
    output logic             directIsSfr,
    output logic             clearTestedBit,
    output logic [7:0]       sfrRdata,
    output logic [7:0]       stackAddr,    // Address written or read
    output logic [7:0]       stackTop,
    output logic [15:0]      dataPointer
);
    logic [2:0]  remain;       // Cycles left after the current edge
    logic [2:0]  next_remain;
    logic        accept;
    logic [1:0]  len;          // Decoded byte count
    logic [2:0]  baseCyc;      // Cycles when not taken
    logic        isCond;       // Conditional branch
    logic        take;         // Condition holds
    target_e     kind;
    logic [15:0] nextPc;
    logic [7:0]  relByte;
    logic [7:0]  pushTop;

    assign accept = instrValid && ready;
    assign nextPc = pc + {14'h0000, len};
    assign relByte = (len == 2'd3) ? operand2 : operand1;
    assign pushTop = stackTop + 8'h01;

    // Opcode decode: length, cycles and target form
    always_comb begin
        len = 2'd1;
        baseCyc = 3'd1;
        isCond = 1'b0;
        take = 1'b0;
        kind = T_NEXT;
        casez (opcode)
            8'b11001???: begin
                len = 2'd1;
                baseCyc = 3'd1;
            end
            OP_XCH_D: begin
                len = 2'd2;
                baseCyc = 3'd2;
            end
            8'b1100011?, 8'b1101011?: begin
                len = 2'd1;
                baseCyc = 3'd2;
            end
            OP_ANL_B, OP_ANL_NB, OP_ORL_B, OP_ORL_NB, OP_MOV_CB, OP_MOV_BC: begin
                len = 2'd2;
                baseCyc = 3'd2;
            end
            OP_JC, OP_JNC: begin
                len = 2'd2;
                baseCyc = 3'd2;
                isCond = 1'b1;
                take = carryFlag ^ opcode[4];
                kind = T_REL;
            end
            OP_JB, OP_JNB, OP_JBC: begin
                len = 2'd3;
                baseCyc = 3'd3;
                isCond = 1'b1;
                take = (opcode == OP_JNB) ? !testBit : testBit;
                kind = T_REL;
            end
            8'b???00001, 8'b???10001: begin
                len = 2'd2;
                baseCyc = 3'd3;
                kind = T_PAGE;
            end
            OP_LONG_JUMP, OP_LONG_CALL: begin
                len = 2'd3;
                baseCyc = 3'd4;
                kind = T_LONG;
            end
            OP_SHORT_RELATIVE_JUMP: begin
                len = 2'd2;
                baseCyc = 3'd3;
                kind = T_REL;
            end
            OP_JMPI: begin
                len = 2'd1;
                baseCyc = 3'd3;
                kind = T_PTR;
            end
            OP_JZ, OP_JNZ: begin
                len = 2'd2;
                baseCyc = 3'd2;
                isCond = 1'b1;
                take = (accValue == 8'h00) ^ opcode[4];
                kind = T_REL;
            end
            OP_CJ_AD, OP_CJ_AI, 8'b10111???: begin
                len = 2'd3;
                baseCyc = 3'd3;
                isCond = 1'b1;
                take = compareUnequal;
                kind = T_REL;
            end
            8'b1011011?: begin
                len = 2'd3;
                baseCyc = 3'd4;
                isCond = 1'b1;
                take = compareUnequal;
                kind = T_REL;
            end
            OP_DJ_D: begin
                len = 2'd3;
                baseCyc = 3'd3;
                isCond = 1'b1;
                take = decValue != 8'h01;
                kind = T_REL;
            end
            OP_NOP, OP_UNUSED: begin
                len = 2'd1;
                baseCyc = 3'd1;
            end
            // Anything not listed runs as a one-byte, one-cycle step
            default: begin
                len = 2'd1;
                baseCyc = 3'd1;
            end
        endcase
    end

    // Next cycle count; a taken branch costs one cycle more
    always_comb begin
        if (accept) begin
            next_remain = baseCyc + {2'b00, isCond && take} - 3'd1;
        end else if (remain != 3'd0) begin
            next_remain = remain - 3'd1;
        end else begin
            next_remain = 3'd0;
        end
    end

    // Cycle counter, ready and done
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            remain <= 3'd0;
            ready <= 1'b1;
            done <= 1'b0;
        end else begin
            remain <= next_remain;
            ready <= next_remain == 3'd0;
            // Done marks the edge where the count runs out
            done <= (accept || remain != 3'd0) && next_remain == 3'd0;
        end
    end

    // Decode results held for the whole instruction
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            instrLength <= 2'd0;
            cycleCount <= 3'd0;
            branchTaken <= 1'b0;
            targetAddr <= 16'h0000;
            bankRegAddr <= 8'h00;
            indirectRegAddr <= 8'h00;
            directIsSfr <= 1'b0;
        end else if (accept) begin
            instrLength <= len;
            cycleCount <= baseCyc + {2'b00, isCond && take};
            branchTaken <= (isCond && take) || kind != T_NEXT && !isCond;
            bankRegAddr <= {3'b000, bankSelect, opcode[2:0]};
            indirectRegAddr <= {3'b000, bankSelect, 2'b00, opcode[0]};
            directIsSfr <= operand1 >= SFR_FIRST;
            case (kind)
                T_REL: begin
                    if (!isCond || take) begin
                        targetAddr <= nextPc + {{8{relByte[7]}}, relByte};
                    end else begin
                        targetAddr <= nextPc;
                    end
                end
                T_PAGE: targetAddr <= {nextPc[15:11], opcode[7:5], operand1};
                T_LONG: targetAddr <= {operand1, operand2};
                T_PTR: targetAddr <= dataPointer + {8'h00, accValue};
                default: targetAddr <= nextPc;
            endcase
        end
    end

    // One-cycle clear request for a set bit tested by the clear variant
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clearTestedBit <= 1'b0;
        end else begin
            clearTestedBit <= accept && opcode == OP_JBC && testBit;
        end
    end

    // Data pointer bytes; software writes take effect next cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dataPointer <= {PTR_RESET, PTR_RESET};
        end else if (sfrWrite && sfrAddr == ADDR_PTR_LO) begin
            dataPointer[7:0] <= sfrWdata;
        end else if (sfrWrite && sfrAddr == ADDR_PTR_HI) begin
            dataPointer[15:8] <= sfrWdata;
        end
    end

    // Stack pointer: software write wins over push and pop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stackTop <= STACK_RESET;
            stackAddr <= STACK_RESET;
        end else if (sfrWrite && sfrAddr == ADDR_STACK) begin
            stackTop <= sfrWdata;
        end else if (pushReq) begin
            stackTop <= pushTop;
            stackAddr <= pushTop;
        end else if (popReq) begin
            stackAddr <= stackTop;
            stackTop <= stackTop - 8'h01;
        end
    end

    // Registered read port; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sfrRdata <= 8'h00;
        end else begin
            case (sfrAddr)
                ADDR_STACK: sfrRdata <= stackTop;
                ADDR_PTR_LO: sfrRdata <= dataPointer[7:0];
                ADDR_PTR_HI: sfrRdata <= dataPointer[15:8];
                default: sfrRdata <= 8'h00;
            endcase
        end
    end

    // Checks on timing and addressing
    property p_xch_reg;
        @(posedge clk) disable iff (!rst_n)
        accept && opcode[7:3] == 5'b11001 |=> done && instrLength == 2'd1;
    endproperty
    a_xch_reg: assert property (p_xch_reg) else $error("register exchange timing");

    property p_bit_logic;
        @(posedge clk) disable iff (!rst_n)
        accept && opcode == OP_ANL_B |=> !done && instrLength == 2'd2 ##1 done;
    endproperty
    a_bit_logic: assert property (p_bit_logic) else $error("carry logic timing");

    property p_carry_taken;
        @(posedge clk) disable iff (!rst_n)
        accept && opcode == OP_JC && carryFlag |=> !done [*2] ##1 done;
    endproperty
    a_carry_taken: assert property (p_carry_taken) else $error("carry jump taken");

    property p_bit_clear;
        @(posedge clk) disable iff (!rst_n)
        accept && opcode == OP_JBC && testBit |=> clearTestedBit && cycleCount == 3'd4;
    endproperty
    a_bit_clear: assert property (p_bit_clear) else $error("bit clear missing");

    property p_short;
        @(posedge clk) disable iff (!rst_n)
        accept && opcode == OP_SHORT_RELATIVE_JUMP |=> targetAddr == $past(pc) + 16'd2
            + {{8{$past(operand1[7])}}, $past(operand1)} ##2 done;
    endproperty
    a_short: assert property (p_short) else $error("short jump target");

    property p_indirect_cmp;
        @(posedge clk) disable iff (!rst_n)
        accept && opcode[7:1] == 7'b1011011 && !compareUnequal |=> cycleCount == 3'd4;
    endproperty
    a_indirect_cmp: assert property (p_indirect_cmp) else $error("indirect compare");

    property p_unused_op;
        @(posedge clk) disable iff (!rst_n)
        accept && opcode == OP_UNUSED |=> done && ready && !branchTaken;
    endproperty
    a_unused_op: assert property (p_unused_op) else $error("unused opcode timing");

    property p_page;
        @(posedge clk) disable iff (!rst_n)
        accept && opcode[4:0] == 5'b00001
            |=> targetAddr[15:11] == $past(nextPc[15:11]);
    endproperty
    a_page: assert property (p_page) else $error("page target");

    property p_push;
        @(posedge clk) disable iff (!rst_n)
        pushReq && !sfrWrite |=> stackTop == $past(stackTop) + 8'h01
            && stackAddr == stackTop;
    endproperty
    a_push: assert property (p_push) else $error("push order");

    property p_not_taken;
        @(posedge clk) disable iff (!rst_n)
        accept && opcode == OP_JNC && carryFlag |=> cycleCount == 3'd2 && !done ##1 done;
    endproperty
    a_not_taken: assert property (p_not_taken) else $error("untaken length");
endmodule : core_branch_bit_timing

/* verif/prog_store_model.sv */
`timescale 1ns/100ps
// Code space on the fetch side: answers the three instruction bytes at pc
module prog_store_model (
    input  wire logic [15:0] pc,
    output logic      [7:0]  opcode,
    output logic      [7:0]  operand1,
    output logic      [7:0]  operand2
);
    logic [7:0] mem [0:8191];  // Whole 8 kB code space; pc bits above it are ignored
    // Known contents from time zero so the core never decodes an unknown byte
    initial mem = '{default: 8'h00};
    // Combinational fetch; operand bytes wrap inside the code space
    assign opcode   = mem[pc[12:0]];
    assign operand1 = mem[13'(pc[12:0] + 13'h1)];
    assign operand2 = mem[13'(pc[12:0] + 13'h2)];
endmodule : prog_store_model

/* verif/core_branch_bit_timing_tb.sv */
`timescale 1ns/100ps
module core_branch_bit_timing_tb;
    import core_branch_pkg::*;
    // One row: bytes, condition level, expected length, cycles, taken, target kind
    typedef struct {
        logic [7:0] op, o1, o2;
        logic       c;
        logic [1:0] len;
        logic [2:0] cyc;
        logic       tk;
        target_e    k;
    } row_s;
    // Opcode two bytes below a 2 kB boundary, so page targets use the next page
    localparam logic [15:0] PC = 16'h07fe;
    logic        clk, rst_n, instrValid, carryFlag, testBit, compareUnequal;
    logic        sfrWrite, pushReq, popReq, ready, done, branchTaken, directIsSfr;
    logic        clearTestedBit;
    logic [1:0]  bankSelect, instrLength;
    logic [2:0]  cycleCount;
    logic [7:0]  opcode, operand1, operand2, accValue, decValue, sfrAddr, sfrWdata;
    logic [7:0]  bankRegAddr, indirectRegAddr, sfrRdata, stackAddr, stackTop;
    logic [15:0] pc, targetAddr, dataPointer;
    int          errorCnt, nChecks;
    row_s        rows [35] = '{
        '{8'h00,8'h00,8'h00,1'h0,2'h1,3'h1,1'h0,T_NEXT},
        '{8'ha5,8'h00,8'h00,1'h0,2'h1,3'h1,1'h0,T_NEXT},
        '{8'hcf,8'h00,8'h00,1'h0,2'h1,3'h1,1'h0,T_NEXT},
        '{8'hc5,8'h90,8'h00,1'h0,2'h2,3'h2,1'h0,T_NEXT},
        '{8'hc6,8'h00,8'h00,1'h0,2'h1,3'h2,1'h0,T_NEXT},
        '{8'hd7,8'h00,8'h00,1'h0,2'h1,3'h2,1'h0,T_NEXT},
        '{8'h82,8'h20,8'h00,1'h0,2'h2,3'h2,1'h0,T_NEXT},
        '{8'hb0,8'ha0,8'h00,1'h0,2'h2,3'h2,1'h0,T_NEXT},
        '{8'h72,8'h20,8'h00,1'h0,2'h2,3'h2,1'h0,T_NEXT},
        '{8'ha0,8'ha0,8'h00,1'h0,2'h2,3'h2,1'h0,T_NEXT},
        '{8'ha2,8'h20,8'h00,1'h0,2'h2,3'h2,1'h0,T_NEXT},
        '{8'h92,8'ha0,8'h00,1'h0,2'h2,3'h2,1'h0,T_NEXT},
        '{8'h40,8'h10,8'h00,1'h1,2'h2,3'h3,1'h1,T_REL},
        '{8'h40,8'h10,8'h00,1'h0,2'h2,3'h2,1'h0,T_REL},
        '{8'h50,8'hf0,8'h00,1'h1,2'h2,3'h2,1'h0,T_REL},
        '{8'h50,8'hf0,8'h00,1'h0,2'h2,3'h3,1'h1,T_REL},
        '{8'h20,8'h20,8'hf0,1'h1,2'h3,3'h4,1'h1,T_REL},
        '{8'h30,8'h20,8'hf0,1'h1,2'h3,3'h3,1'h0,T_REL},
        '{8'h10,8'h20,8'h80,1'h1,2'h3,3'h4,1'h1,T_REL},
        '{8'h10,8'h20,8'h80,1'h0,2'h3,3'h3,1'h0,T_REL},
        '{8'h21,8'h34,8'h00,1'h0,2'h2,3'h3,1'h1,T_PAGE},
        '{8'hf1,8'h34,8'h00,1'h0,2'h2,3'h3,1'h1,T_PAGE},
        '{8'h02,8'h1f,8'hff,1'h0,2'h3,3'h4,1'h1,T_LONG},
        '{8'h12,8'h00,8'h01,1'h0,2'h3,3'h4,1'h1,T_LONG},
        '{8'h80,8'h80,8'h00,1'h0,2'h2,3'h3,1'h1,T_REL},
        '{8'h73,8'h00,8'h00,1'h1,2'h1,3'h3,1'h1,T_PTR},
        '{8'h60,8'h7f,8'h00,1'h1,2'h2,3'h3,1'h1,T_REL},
        '{8'h70,8'h7f,8'h00,1'h1,2'h2,3'h2,1'h0,T_REL},
        '{8'hb5,8'h85,8'h10,1'h1,2'h3,3'h4,1'h1,T_REL},
        '{8'hb4,8'h55,8'h10,1'h0,2'h3,3'h3,1'h0,T_REL},
        '{8'hbb,8'h55,8'h10,1'h1,2'h3,3'h4,1'h1,T_REL},
        '{8'hb7,8'h55,8'hfe,1'h1,2'h3,3'h5,1'h1,T_REL},
        '{8'hb6,8'h55,8'hfe,1'h0,2'h3,3'h4,1'h0,T_REL},
        '{8'hd5,8'h30,8'hf8,1'h1,2'h3,3'h4,1'h1,T_REL},
        '{8'hd5,8'h30,8'hf8,1'h0,2'h3,3'h3,1'h0,T_REL}};

    core_branch_bit_timing i_dut (.clk, .rst_n, .instrValid, .opcode, .operand1, .operand2, .pc,
        .bankSelect, .carryFlag, .accValue, .testBit, .compareUnequal, .decValue, .sfrWrite,
        .sfrAddr, .sfrWdata, .pushReq, .popReq, .ready, .done, .instrLength, .cycleCount,
        .branchTaken, .targetAddr, .bankRegAddr, .indirectRegAddr, .directIsSfr, .clearTestedBit,
        .sfrRdata, .stackAddr, .stackTop, .dataPointer);
    prog_store_model i_mem (.pc, .opcode, .operand1, .operand2);

    // Free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Compare one value; the width covers the widest output
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        nChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // Print the counts and the verdict, then stop
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrapUp

    // Twenty cycles of reset; outputs are looked at just after release
    task automatic doReset();
        // Assert on an edge so a mid-run reset never changes between edges
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1;
    endtask : doReset

    // One special-register cycle with optional write and stack requests
    task automatic busOp(input logic w, input logic [7:0] a, d, input logic pu, po);
        @(posedge clk);
        sfrWrite <= w;
        sfrAddr <= a;
        sfrWdata <= d;
        pushReq <= pu;
        popReq <= po;
        @(posedge clk);
        sfrWrite <= 1'b0;
        pushReq <= 1'b0;
        popReq <= 1'b0;
        #1;
    endtask : busOp

    // Expected next address; untaken branches simply fall through
    function automatic logic [15:0] expTarget(input row_s r);
        logic [15:0] nx;
        logic [7:0]  rb;
        nx = PC + 16'(r.len);
        rb = (r.len == 2'h3) ? r.o2 : r.o1;
        if (!r.tk) return nx;
        case (r.k)
            T_REL:   return nx + {{8{rb[7]}}, rb};
            T_PAGE:  return {nx[15:11], r.op[7:5], r.o1};
            T_LONG:  return {r.o1, r.o2};
            T_PTR:   return 16'ha55a;  // Accumulator held at zero in that row
            default: return nx;
        endcase
    endfunction : expTarget

    // Issue one instruction, count cycles up to done, then compare decode results
    task automatic runRow(input row_s r, input logic [1:0] bank);
        int n;
        n = 1;
        @(posedge clk);
        {i_mem.mem[13'h07fe], i_mem.mem[13'h07ff], i_mem.mem[13'h0800]} <= {r.op, r.o1, r.o2};
        instrValid <= 1'b1;
        bankSelect <= bank;
        carryFlag <= r.c;
        testBit <= r.c;
        compareUnequal <= r.c;
        accValue <= r.c ? 8'h00 : 8'h33;
        decValue <= r.c ? 8'h05 : 8'h01;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
        check(16'(clearTestedBit), 16'(r.op == OP_JBC && r.c), "bit clear pulse");
        // Bounded wait: no instruction here lasts beyond five cycles
        while (done !== 1'b1 && n < 8) begin
            check(16'(ready), 16'h0, "ready while busy");
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(n), 16'(r.cyc), "cycles to done");
        check(16'(cycleCount), 16'(r.cyc), "cycle count");
        check(16'(instrLength), 16'(r.len), "length");
        check(16'(branchTaken), 16'(r.tk), "taken");
        check(targetAddr, expTarget(r), "target");
        check(16'(bankRegAddr), {11'h0, bank, r.op[2:0]}, "bank reg");
        check(16'(indirectRegAddr), {11'h0, bank, 2'h0, r.op[0]}, "indirect");
        check(16'(directIsSfr), 16'(r.o1[7]), "direct space");
    endtask : runRow

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        errorCnt++;
        wrapUp();
    end

    // Main sequence
    initial begin
        {rst_n, instrValid, carryFlag, testBit, compareUnequal, sfrWrite, pushReq, popReq} = '0;
        {bankSelect, accValue, decValue, sfrAddr, sfrWdata} = '0;
        pc = PC;
        doReset();
        check(16'(ready), 16'h1, "ready after reset");
        check(16'(stackTop), 16'h0007, "stack reset");
        check(dataPointer, 16'h0000, "pointer reset");
        busOp(1'b1, 8'h82, 8'h5a, 1'b0, 1'b0);
        busOp(1'b1, 8'h83, 8'ha5, 1'b0, 1'b0);
        check(dataPointer, 16'ha55a, "pointer write");
        busOp(1'b0, 8'h83, 8'h00, 1'b0, 1'b0);
        check(16'(sfrRdata), 16'h00a5, "high byte read");
        busOp(1'b0, 8'h82, 8'h00, 1'b0, 1'b0);
        check(16'(sfrRdata), 16'h005a, "low byte read");
        busOp(1'b0, 8'h84, 8'h00, 1'b0, 1'b0);
        check(16'(sfrRdata), 16'h0000, "unmapped read");
        busOp(1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
        check({stackTop, stackAddr}, 16'h0808, "push");
        busOp(1'b0, 8'h81, 8'h00, 1'b0, 1'b1);
        check({stackTop, stackAddr}, 16'h0708, "pop");
        check(16'(sfrRdata), 16'h0008, "stack read");
        busOp(1'b1, 8'h81, 8'h30, 1'b1, 1'b0);
        check(16'(stackTop), 16'h0030, "write beats push");
        foreach (rows[i]) runRow(rows[i], 2'(i));
        // Reset in mid-run must bring the core registers back
        doReset();
        check({stackTop, dataPointer[7:0]}, 16'h0700, "second reset");
        check(16'(dataPointer[15:8]), 16'h0000, "second reset high");
        wrapUp();
    end
endmodule : core_branch_bit_timing_tb
